// [ccsc_device_end.sv]
// Codec device end: power-on reset, boot, control registers and core clock
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Power-on reset loads every register default
// - Boot clears internal memory before anything else
// - Control port opens only after boot
// - Bypass takes core clock from master pin
// - Host sets ratio field 256/512/768/1024
// - Core clock stopped until enable bit set
// - Core clock off while PLL acquires lock, when bit three selects PLL
// - Lock bit readable; host polls before enabling
// - During lock only two control registers served
// - Host touches nothing else until enabled, locked
// - PLL setup written whole, six bytes
// - Lock takes about 2.4 to 3.0 ms
// - PLL reference stays within 11-20 MHz
// - Converter oversampling selectable 64 or 128
// - Sample rate divided from base, 8-96 kHz
// - PLL selection forces core divider by four
// - Bit three selects master pin or PLL
// - Core clock always 256 times base rate
module ccsc_device_end
	import ccsc_pkg::*;
#(
	parameter int LOCK_CYCLES_P = LOCK_CYCLES,
	parameter int BOOT_CYCLES_P = BOOT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	ccsc_if.device link,
	input wire logic regulator_output_pin,
	input wire logic master_clock_pin,
	input wire logic pll_output_tick,
	output logic boot_done,
	output logic pll_locked,
	output logic core_clock_enable,
	output logic core_clock_tick,
	output logic sample_tick,
	output logic oversample_64,
	output logic [2:0] converter_rate
);
	typedef enum {ST_POR, ST_BOOT, ST_RUN} ccsc_dev_state_t;

	function automatic logic [10:0] sample_period(input logic [2:0] rate);
		case (rate)
			3'h1: sample_period = BASE_FS_TICKS * 11'h6;
			3'h2: sample_period = BASE_FS_TICKS * 11'h4;
			3'h3: sample_period = BASE_FS_TICKS * 11'h3;
			3'h4: sample_period = BASE_FS_TICKS * 11'h2;
			3'h5: sample_period = BASE_FS_TICKS + (BASE_FS_TICKS >> 1);
			3'h6: sample_period = BASE_FS_TICKS >> 1;
			default: sample_period = BASE_FS_TICKS;
		endcase
	endfunction

	localparam int BW = $clog2(BOOT_CYCLES_P + 1);
	ccsc_dev_state_t state;
	logic [2:0] power_sync;
	logic power_ok;
	logic por;
	logic [BW-1:0] boot_count;
	logic [7:0] clock_control;
	logic [47:0] pll_setup;
	logic [7:0] mem [MEM_WORDS];
	logic pll_restart;
	logic locked;
	logic [2:0] mclk_sync;
	logic mclk_level;
	logic mclk_edge;
	logic [1:0] div_count;
	logic [10:0] fs_count;
	logic core_on;
	logic accept;
	logic is_ctl;
	logic in_mem;
	logic open_access;
	logic refused;
	logic [3:0] mem_idx;
	logic src_tick;
	logic [2:0] divide;

	// Regulator output watched through three flops
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			power_sync <= 3'h0;
			power_ok <= 1'b0;
		end else begin
			power_sync <= {power_sync[1:0], regulator_output_pin};
			if (power_sync[1] == power_sync[2]) begin
				power_ok <= power_sync[2];
			end
		end
	end
	assign por = !power_ok;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= ST_POR;
			boot_count <= '0;
		end else if (por) begin
			state <= ST_POR;
			boot_count <= '0;
		end else begin
			case (state)
				ST_POR: state <= ST_BOOT;
				ST_BOOT: begin
					boot_count <= boot_count + BW'(1);
					if (boot_count == BW'(BOOT_CYCLES_P - 1)) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: state <= ST_RUN;
				default: state <= ST_POR;
			endcase
		end
	end

	assign link.req_ready = (state == ST_RUN);
	assign accept = link.req_valid && link.req_ready;
	assign is_ctl = (link.req_addr == ADDR_CLOCK_CONTROL) || (link.req_addr == ADDR_PLL_SETUP);
	assign in_mem = (link.req_addr[15:4] == ADDR_MEM_BASE[15:4]);
	assign mem_idx = link.req_addr[3:0];
	assign open_access = clock_control[CC_ENABLE_BIT] && (!clock_control[CC_SRC_BIT] || locked);
	always_comb begin
		refused = 1'b0;
		if (!is_ctl && !open_access) begin
			refused = 1'b1;
		end else if (!is_ctl && !in_mem) begin
			refused = 1'b1;
		end else if (link.req_write && link.req_addr == ADDR_PLL_SETUP
			&& link.req_len != PLL_SETUP_BYTES) begin
			refused = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clock_control <= CC_RESET;
			pll_setup <= PLL_RESET;
			pll_restart <= 1'b0;
		end else if (state != ST_RUN) begin
			clock_control <= CC_RESET;
			pll_setup <= PLL_RESET;
			pll_restart <= 1'b0;
		end else begin
			pll_restart <= 1'b0;
			if (accept && link.req_write && !refused) begin
				if (link.req_addr == ADDR_CLOCK_CONTROL) begin
					clock_control <= link.req_data[7:0];
				end
				if (link.req_addr == ADDR_PLL_SETUP) begin
					pll_setup <= link.req_data;
					pll_restart <= 1'b1;
				end
			end
		end
	end

	// Memory cleared word by word during boot
	always_ff @(posedge clk_sys) begin
		if (state == ST_BOOT) begin
			mem[boot_count[3:0]] <= MEM_RESET;
		end else if (state == ST_RUN && accept && link.req_write && !refused && in_mem) begin
			mem[mem_idx] <= link.req_data[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			link.resp_valid <= 1'b0;
			link.resp_error <= 1'b0;
			link.resp_data <= '0;
		end else begin
			link.resp_valid <= accept;
			link.resp_error <= accept && refused;
			link.resp_data <= '0;
			if (accept && !refused && !link.req_write) begin
				if (link.req_addr == ADDR_CLOCK_CONTROL) begin
					link.resp_data <= {40'h0, clock_control};
				end else if (link.req_addr == ADDR_PLL_SETUP) begin
					link.resp_data <= pll_setup;
					link.resp_data[PLL_LOCK_BIT] <= locked;
				end else begin
					link.resp_data <= {40'h0, mem[mem_idx]};
				end
			end
		end
	end

	ccsc_lock_timer #(
		.CYCLES(LOCK_CYCLES_P)
	) u_lock (
		.clk_sys(clk_sys),
		.reset(reset),
		.enable(pll_setup[PLL_ENABLE_BIT] && state == ST_RUN),
		.restart(pll_restart),
		.locked(locked)
	);

	// Master clock pin sampled through three flops
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mclk_sync <= 3'h0;
			mclk_level <= 1'b0;
			mclk_edge <= 1'b0;
		end else begin
			mclk_sync <= {mclk_sync[1:0], master_clock_pin};
			mclk_edge <= 1'b0;
			if (mclk_sync[1] == mclk_sync[2]) begin
				mclk_level <= mclk_sync[2];
				mclk_edge <= mclk_sync[2] && !mclk_level;
			end
		end
	end

	assign src_tick = clock_control[CC_SRC_BIT] ? pll_output_tick : mclk_edge;
	assign divide = clock_control[CC_SRC_BIT] ? PLL_CORE_DIV
		: {1'b0, clock_control[CC_RATIO_LSB +: 2]} + 3'h1;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			core_on <= 1'b0;
		end else begin
			core_on <= clock_control[CC_ENABLE_BIT] && state == ST_RUN
				&& (!clock_control[CC_SRC_BIT] || locked);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_count <= 2'h0;
			core_clock_tick <= 1'b0;
		end else if (!core_on) begin
			div_count <= 2'h0;
			core_clock_tick <= 1'b0;
		end else begin
			core_clock_tick <= 1'b0;
			if (src_tick) begin
				if ({1'b0, div_count} >= divide - 3'h1) begin
					div_count <= 2'h0;
					core_clock_tick <= 1'b1;
				end else begin
					div_count <= div_count + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fs_count <= 11'h0;
			sample_tick <= 1'b0;
		end else if (!core_on) begin
			fs_count <= 11'h0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if (core_clock_tick) begin
				if (fs_count >= sample_period(converter_rate) - 11'h1) begin
					fs_count <= 11'h0;
					sample_tick <= 1'b1;
				end else begin
					fs_count <= fs_count + 11'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			oversample_64 <= 1'b0;
			converter_rate <= 3'h0;
			boot_done <= 1'b0;
			pll_locked <= 1'b0;
			core_clock_enable <= 1'b0;
		end else begin
			oversample_64 <= (state == ST_RUN) && mem[ADDR_CONVERTER[3:0]][CONV_OSR64_BIT];
			converter_rate <= (state == ST_RUN) ? mem[ADDR_CONVERTER[3:0]][CONV_RATE_LSB +: 3] : 3'h0;
			boot_done <= (state == ST_RUN);
			pll_locked <= locked;
			core_clock_enable <= core_on;
		end
	end
endmodule
`default_nettype wire

// [ccsc_pkg.sv]
// Shared constants for the codec clock and start-up control ends
package ccsc_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int LOCK_TIME_US = 3000;
	localparam int LOCK_CYCLES = LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int MEM_WORDS = 16;
	localparam int BOOT_CYCLES = 16;

	localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'h4000;
	localparam logic [15:0] ADDR_PLL_SETUP = 16'h4002;
	localparam logic [15:0] ADDR_MEM_BASE = 16'h4010;
	localparam logic [15:0] ADDR_CONVERTER = 16'h4017;

	localparam int CC_ENABLE_BIT = 0;
	localparam int CC_RATIO_LSB = 1;
	localparam int CC_SRC_BIT = 3;
	localparam int PLL_ENABLE_BIT = 0;
	localparam int PLL_LOCK_BIT = 1;
	localparam int CONV_RATE_LSB = 0;
	localparam int CONV_OSR64_BIT = 3;

	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [47:0] PLL_RESET = 48'h000000000000;
	localparam logic [7:0] MEM_RESET = 8'h00;
	localparam logic [2:0] PLL_CORE_DIV = 3'h4;
	localparam logic [2:0] PLL_SETUP_BYTES = 3'h6;
	localparam logic [10:0] BASE_FS_TICKS = 11'h100;

	localparam logic [7:0] WB_CMD = 8'h00;
	localparam logic [7:0] WB_WDATA_LO = 8'h04;
	localparam logic [7:0] WB_WDATA_HI = 8'h08;
	localparam logic [7:0] WB_STATUS = 8'h0c;
	localparam logic [7:0] WB_RDATA_LO = 8'h10;
	localparam logic [7:0] WB_RDATA_HI = 8'h14;
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_WE_BIT = 16;
	localparam int CMD_LEN_LSB = 17;
	localparam int CMD_GO_BIT = 31;
endpackage

// [ccsc_if.sv]
// Control-port link between host controller and codec device
`timescale 1ns/100ps
`default_nettype none
interface ccsc_if;
	logic req_valid;
	logic req_ready;
	logic req_write;
	logic [15:0] req_addr;
	logic [47:0] req_data;
	logic [2:0] req_len;
	logic resp_valid;
	logic resp_error;
	logic [47:0] resp_data;
	modport device(input req_valid, req_write, req_addr, req_data, req_len,
		output req_ready, resp_valid, resp_error, resp_data);
	modport host(output req_valid, req_write, req_addr, req_data, req_len,
		input req_ready, resp_valid, resp_error, resp_data);
endinterface
`default_nettype wire

// [ccsc_lock_timer.sv]
// Lock acquisition timer for the PLL model
`timescale 1ns/100ps
`default_nettype none
module ccsc_lock_timer #(
	parameter int CYCLES = 750000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic enable,
	input wire logic restart,
	output logic locked
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES);
	logic [W-1:0] count;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count <= '0;
			locked <= 1'b0;
		end else if (!enable || restart) begin
			count <= '0;
			locked <= 1'b0;
		end else if (count == LAST) begin
			locked <= 1'b1;
		end else begin
			count <= count + W'(1);
		end
	end
endmodule
`default_nettype wire

// [ccsc_host_end.sv]
// Host controller end: Wishbone command registers driving the control port
`timescale 1ns/100ps
`default_nettype none
module ccsc_host_end
	import ccsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdata,
	output logic [31:0] wb_rdata,
	output logic wb_ack,
	ccsc_if.host link
);
	typedef enum {HS_IDLE, HS_REQ, HS_WAIT} ccsc_host_state_t;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	ccsc_host_state_t state;
	logic [31:0] cmd;
	logic [31:0] wdata_lo;
	logic [31:0] wdata_hi;
	logic [47:0] rdata;
	logic done;
	logic error;
	logic seen_enable;
	logic seen_lock;
	logic wb_hit;
	logic wb_take;
	logic go;
	logic ctl_addr;
	logic [15:0] go_addr;

	assign wb_hit = wb_cyc && wb_stb && !wb_ack;
	// Writes take effect at the edge where the master sees ack high
	assign wb_take = wb_cyc && wb_stb && wb_ack;
	assign go = wb_take && wb_we && wb_adr == WB_CMD && wb_sel[3] && wb_wdata[CMD_GO_BIT]
		&& state == HS_IDLE;
	assign go_addr = wb_wdata[CMD_ADDR_LSB +: 16];
	assign ctl_addr = go_addr == ADDR_CLOCK_CONTROL || go_addr == ADDR_PLL_SETUP;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wb_ack <= 1'b0;
			wb_rdata <= 32'h0;
		end else begin
			wb_ack <= wb_hit;
			wb_rdata <= 32'h0;
			if (wb_hit && !wb_we) begin
				case (wb_adr)
					WB_CMD: wb_rdata <= cmd;
					WB_WDATA_LO: wb_rdata <= wdata_lo;
					WB_WDATA_HI: wb_rdata <= wdata_hi;
					WB_STATUS: wb_rdata <= {28'h0, seen_enable && seen_lock, error, done,
						state != HS_IDLE};
					WB_RDATA_LO: wb_rdata <= rdata[31:0];
					WB_RDATA_HI: wb_rdata <= {16'h0, rdata[47:32]};
					default: wb_rdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wdata_lo <= 32'h0;
			wdata_hi <= 32'h0;
		end else if (wb_take && wb_we) begin
			if (wb_adr == WB_WDATA_LO) begin
				wdata_lo <= merge(wdata_lo, wb_wdata, wb_sel);
			end
			if (wb_adr == WB_WDATA_HI) begin
				wdata_hi <= merge(wdata_hi, wb_wdata, wb_sel) & 32'h0000ffff;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= HS_IDLE;
			cmd <= 32'h0;
			done <= 1'b0;
			error <= 1'b0;
			rdata <= 48'h0;
			link.req_valid <= 1'b0;
			link.req_write <= 1'b0;
			link.req_addr <= 16'h0;
			link.req_data <= 48'h0;
			link.req_len <= 3'h0;
		end else begin
			case (state)
				HS_IDLE: begin
					if (go) begin
						cmd <= wb_wdata & 32'h7fffffff;
						done <= 1'b0;
						error <= 1'b0;
						if (!ctl_addr && !(seen_enable && seen_lock)) begin
							done <= 1'b1;
							error <= 1'b1;
						end else begin
							state <= HS_REQ;
							link.req_valid <= 1'b1;
							link.req_write <= wb_wdata[CMD_WE_BIT];
							link.req_addr <= go_addr;
							link.req_data <= {wdata_hi[15:0], wdata_lo};
							link.req_len <= (go_addr == ADDR_PLL_SETUP) ? PLL_SETUP_BYTES
								: wb_wdata[CMD_LEN_LSB +: 3];
						end
					end
				end
				HS_REQ: begin
					if (link.req_ready) begin
						link.req_valid <= 1'b0;
						state <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (link.resp_valid) begin
						rdata <= link.resp_data;
						error <= link.resp_error;
						done <= 1'b1;
						state <= HS_IDLE;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

	// Track what the host has seen of enable and lock
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			seen_enable <= 1'b0;
			seen_lock <= 1'b0;
		end else if (state == HS_WAIT && link.resp_valid && !link.resp_error) begin
			if (link.req_addr == ADDR_CLOCK_CONTROL) begin
				seen_enable <= link.req_write ? link.req_data[CC_ENABLE_BIT]
					: link.resp_data[CC_ENABLE_BIT];
			end
			if (link.req_addr == ADDR_PLL_SETUP) begin
				seen_lock <= !link.req_write && link.resp_data[PLL_LOCK_BIT];
			end
		end
	end
endmodule
`default_nettype wire

// [ccsc_chk.sv]
// Assertions on the control-port link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module ccsc_chk
	import ccsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [15:0] req_addr,
	input wire logic [47:0] req_data,
	input wire logic [2:0] req_len,
	input wire logic resp_valid,
	input wire logic resp_error,
	input wire logic [47:0] resp_data
);
	logic take;
	logic pll_wr;
	logic [5:0] since_pll;
	assign take = req_valid && req_ready;
	assign pll_wr = take && req_write && req_addr == ADDR_PLL_SETUP;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			since_pll <= 6'h3f;
		end else if (pll_wr) begin
			since_pll <= 6'h00;
		end else if (since_pll != 6'h3f) begin
			since_pll <= since_pll + 6'h01;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_answer_next_cycle: assert property (take |=> resp_valid)
		else $error("request taken without answer");
	a_answer_has_cause: assert property (resp_valid |-> $past(take))
		else $error("answer without request");
	a_boot_before_open: assert property ($fell(reset) |-> !req_ready [*8])
		else $error("port open before boot");
	a_request_held: assert property (req_valid && !req_ready |=>
		req_valid && $stable(req_addr) && $stable(req_data)) else $error("request dropped");
	a_setup_whole: assert property (pll_wr |-> req_len == PLL_SETUP_BYTES)
		else $error("partial pll setup write");
	a_setup_accepted: assert property (pll_wr |=> resp_valid && !resp_error)
		else $error("pll setup write refused");
	a_control_served: assert property (take && req_addr == ADDR_CLOCK_CONTROL |=>
		resp_valid && !resp_error) else $error("clock control refused");
	a_refused_empty: assert property (resp_valid && resp_error |-> resp_data == 48'h0)
		else $error("refused answer carries data");
	a_write_no_data: assert property (take && req_write |=> resp_data == 48'h0)
		else $error("write answer carries data");
	a_lock_restarts: assert property (take && !req_write && req_addr == ADDR_PLL_SETUP &&
		since_pll < 6'h28 |=> !resp_data[PLL_LOCK_BIT]) else $error("lock set too soon");
	cover property (pll_wr);
	cover property (resp_valid && resp_error);
	cover property (take && req_addr == ADDR_CONVERTER);
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench joining host end and device end over the control-port link
`timescale 1ns/100ps
`default_nettype none
module tb_top import ccsc_pkg::*;;
	localparam int LOCK_P = 50;
	localparam int MCLK_TICKS = 4;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdata = 32'h0;
	logic [31:0] wb_rdata;
	logic wb_ack;
	logic regulator_output_pin = 1'b1;
	logic master_clock_pin = 1'b0;
	logic pll_output_tick = 1'b0;
	logic boot_done, pll_locked, core_clock_enable, core_clock_tick, sample_tick, oversample_64;
	logic [2:0] converter_rate;
	logic err;
	logic [47:0] rd;
	logic [31:0] q;
	int p;
	int n_fail = 0;
	int samples_checked = 0;
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (pll_output_tick) begin
			master_clock_pin <= ~master_clock_pin;
		end
		pll_output_tick <= ~pll_output_tick;
	end
	ccsc_if link ();
	ccsc_host_end u_ccsc_host_end (.clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
		.wb_rdata(wb_rdata), .wb_ack(wb_ack), .link(link));
	ccsc_device_end #(.LOCK_CYCLES_P(LOCK_P), .BOOT_CYCLES_P(BOOT_CYCLES)) u_ccsc_device_end (
		.clk_sys(clk_sys), .reset(reset), .link(link),
		.regulator_output_pin(regulator_output_pin), .master_clock_pin(master_clock_pin),
		.pll_output_tick(pll_output_tick), .boot_done(boot_done), .pll_locked(pll_locked),
		.core_clock_enable(core_clock_enable), .core_clock_tick(core_clock_tick),
		.sample_tick(sample_tick), .oversample_64(oversample_64),
		.converter_rate(converter_rate));
	ccsc_chk u_chk (.clk_sys(clk_sys), .reset(reset), .req_valid(link.req_valid),
		.req_ready(link.req_ready), .req_write(link.req_write), .req_addr(link.req_addr),
		.req_data(link.req_data), .req_len(link.req_len), .resp_valid(link.resp_valid),
		.resp_error(link.resp_error), .resp_data(link.resp_data));
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_wdata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (wb_ack !== 1'b1) n_fail++;
		q = wb_rdata;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task op(input logic we, input logic [15:0] a, input logic [47:0] d);
		int n;
		logic [2:0] len;
		n = 0;
		len = (a == ADDR_PLL_SETUP) ? PLL_SETUP_BYTES : 3'h1;
		wb(1'b1, WB_WDATA_LO, d[31:0]);
		wb(1'b1, WB_WDATA_HI, {16'h0000, d[47:32]});
		wb(1'b1, WB_CMD, {1'b1, 11'h000, len, we, a});
		do begin
			wb(1'b0, WB_STATUS, 32'h0);
			n++;
		end while (q[1] !== 1'b1 && n < 100);
		if (q[1] !== 1'b1) n_fail++;
		err = q[2];
		wb(1'b0, WB_RDATA_LO, 32'h0);
		rd[31:0] = q;
		wb(1'b0, WB_RDATA_HI, 32'h0);
		rd[47:32] = q[15:0];
	endtask
	task wait_boot;
		int n;
		n = 0;
		while (boot_done !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		if (boot_done !== 1'b1) n_fail++;
	endtask
	task measure(input logic which, input int limit, output int per);
		int n;
		int k;
		int t0;
		n = 0;
		k = 0;
		t0 = 0;
		per = 0;
		while (n < limit) begin
			@(posedge clk_sys);
			n++;
			if ((which ? sample_tick : core_clock_tick) === 1'b1) begin
				k++;
				if (k == 3) begin
					per = n - t0;
					n = limit;
				end
				t0 = n;
			end
		end
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		check("ready in boot", link.req_ready, 1'b0);
		wait_boot();
		check("ready after boot", link.req_ready, 1'b1);
		op(1'b0, ADDR_CLOCK_CONTROL, 48'h0);
		check("clock control default", rd, {40'h0, CC_RESET});
		op(1'b0, ADDR_PLL_SETUP, 48'h0);
		check("pll setup default", rd, PLL_RESET);
		measure(1'b0, 40, p);
		check("ticks while gated", p, 0);
		op(1'b0, ADDR_CONVERTER, 48'h0);
		check("early access refused", err, 1'b1);
		$display("test boot done");
		for (int r = 0; r < 4; r++) begin
			op(1'b1, ADDR_CLOCK_CONTROL, 48'(r * 2 + 1));
			check("core enable", core_clock_enable, 1'b1);
			measure(1'b0, 100, p);
			check("bypass period", p, MCLK_TICKS * (r + 1));
		end
		$display("test bypass done");
		op(1'b1, ADDR_CLOCK_CONTROL, 48'h09);
		op(1'b1, ADDR_PLL_SETUP, 48'h1);
		check("lock output", pll_locked, 1'b0);
		check("core gated in lock", core_clock_enable, 1'b0);
		op(1'b0, ADDR_PLL_SETUP, 48'h0);
		check("setup while locking", rd, 48'h1);
		measure(1'b0, 20, p);
		check("core off in lock", p, 0);
		op(1'b0, ADDR_CONVERTER, 48'h0);
		check("locking access refused", err, 1'b1);
		p = 0;
		do begin
			op(1'b0, ADDR_PLL_SETUP, 48'h0);
			p++;
		end while (rd[PLL_LOCK_BIT] !== 1'b1 && p < 50);
		check("lock seen", rd, 48'h3);
		op(1'b1, ADDR_CLOCK_CONTROL, 48'h09);
		measure(1'b0, 100, p);
		check("pll period", p, 8);
		$display("test pll done");
		op(1'b0, ADDR_MEM_BASE, 48'h0);
		check("memory cleared", rd, {40'h0, MEM_RESET});
		for (int r = 0; r < 8; r++) begin
			op(1'b1, ADDR_CONVERTER, 48'(r + (r % 2) * 8));
			check("rate", converter_rate, 48'(r));
			check("oversampling", oversample_64, 48'(r % 2));
		end
		op(1'b1, ADDR_CONVERTER, 48'h06);
		measure(1'b1, 4000, p);
		check("double rate period", p, 1024);
		op(1'b0, 16'h4020, 48'h0);
		check("unmapped refused", err, 1'b1);
		wb(1'b0, 8'h18, 32'h0);
		check("unmapped bus read", q, 48'h0);
		$display("test converter done");
		regulator_output_pin <= 1'b0;
		repeat (10) @(posedge clk_sys);
		check("ready in reset", link.req_ready, 1'b0);
		regulator_output_pin <= 1'b1;
		wait_boot();
		check("enable after reset", core_clock_enable, 1'b0);
		op(1'b0, ADDR_CONVERTER, 48'h0);
		check("closed after reset", err, 1'b1);
		op(1'b0, ADDR_CLOCK_CONTROL, 48'h0);
		check("control after reset", rd, {40'h0, CC_RESET});
		$display("test power cycle done");
		stop_test();
	end
endmodule
`default_nettype wire
